// [hdl/stop_keepalive.sv]
// Stop-mode keep-alive registers and per-peripheral clock gates.
// Assumes a Wishbone classic master on clk_i and a power controller on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "keepalive_defs.svh"
module stop_keepalive (
  input  wire logic                     clk_i,          // System bus clock, 10 MHz.
  input  wire logic                     rst_i,          // Synchronous reset, active high.
  input  wire logic                     cyc_i,          // Wishbone cycle.
  input  wire logic                     stb_i,          // Wishbone strobe.
  input  wire logic                     we_i,           // Wishbone write.
  input  wire logic [7:0]               adr_i,          // Word index.
  input  wire logic [3:0]               sel_i,          // Byte selects.
  input  wire logic [31:0]              dat_i,          // Write data.
  output logic      [31:0]              dat_o,          // Read data.
  output logic                          ack_o,          // Wishbone acknowledge.
  input  wire keepalive_pkg::per_vec_t  clk_enable_i,   // Peripheral clock-enable bits.
  input  wire logic                     stop_req_i,     // Power controller requests stop.
  input  wire logic                     irq_i,          // Any asserted interrupt.
  output logic                          stop_mode_o,    // Chip is in stop mode.
  output keepalive_pkg::per_vec_t       clk_gate_o,     // Per-peripheral gated clocks.
  output logic                          twowire_nostop_o // Blocks two-wire own stop.
);
  import keepalive_pkg::*;

  ka_state_t st_ff;
  ka_state_t nxt_st;
  per_vec_t  ka_vec;
  per_vec_t  gate_en;
  per_vec_t  latch_en;
  logic      req;

  assign req = cyc_i && stb_i && !st_ff.ack;

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.ack = req;
    nxt_st.dat = 32'h0;
    // Interrupt wins over a stop request so wakeup is never missed.
    if (irq_i) begin
      nxt_st.stop = 1'b0;
    end else if (stop_req_i) begin
      nxt_st.stop = 1'b1;
    end
    if (req) begin
      if (adr_i == `KA_ONE_IDX) begin
        nxt_st.dat = {16'h0, st_ff.ka_one};
        if (we_i && sel_i[0]) begin
          nxt_st.ka_one[7:0] = dat_i[7:0] & `KA_ONE_MASK_LO;
        end
        if (we_i && sel_i[1]) begin
          nxt_st.ka_one[15:8] = dat_i[15:8] & `KA_ONE_MASK_HI;
        end
      end else if (adr_i == `KA_TWO_IDX) begin
        nxt_st.dat = {16'h0, st_ff.ka_two};
        if (we_i && sel_i[0]) begin
          nxt_st.ka_two[7:0] = dat_i[7:0] & `KA_TWO_MASK_LO;
        end
        if (we_i && sel_i[1]) begin
          nxt_st.ka_two[15:8] = dat_i[15:8] & `KA_TWO_MASK_HI;
        end
      end
    end
    if (rst_i) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  assign ka_vec[PER_CAN]     = st_ff.ka_one[`KA_BIT_CAN];
  assign ka_vec[PER_TWOWIRE] = st_ff.ka_one[`KA_BIT_TWOWIRE];
  assign ka_vec[PER_FLASH1]  = st_ff.ka_one[`KA_BIT_FLASH1];
  assign ka_vec[PER_CYCLIC_CONVERTER_KEEPALIVE]  = st_ff.ka_two[`KA_BIT_CYCLIC_CONVERTER_KEEPALIVE];
  assign ka_vec[7:4]         = st_ff.ka_two[`KA_BIT_COMPARATOR_A_KEEPALIVE:`KA_BIT_COMPARATOR_D_KEEPALIVE];

  // Enable is AND of clock-enable and (run or keep-alive); 1 keeps the clock.
  assign gate_en = clk_enable_i & (~{8{st_ff.stop}} | ka_vec);

  // Latch enable while the clock is low so the gated clock never glitches.
  always_latch begin
    if (!clk_i) begin
      latch_en = gate_en;
    end
  end

  assign clk_gate_o       = {8{clk_i}} & latch_en;
  assign twowire_nostop_o = st_ff.stop && ka_vec[PER_TWOWIRE];
  assign stop_mode_o      = st_ff.stop;
  assign ack_o            = st_ff.ack;
  assign dat_o            = st_ff.dat;

  // Checks below watch the gate enables, the registers and the bus answer.
  // Per-peripheral stop and keep-alive checks read the register bits directly, so a wrong
  // mapping between a keep-alive bit and its gate is caught as well.
  // The latch itself is left to the bench, which records which gated clocks pulsed.

  gate_rule_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_enable_i[0] |-> !gate_en[0])
    else $error("gate on with enable low");

  stop_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && !ka_vec[1]) |-> !gate_en[1])
    else $error("stopped clock kept");

  keep_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (clk_enable_i[7] && ka_vec[7]) |-> gate_en[7])
    else $error("keep-alive lost clock");

  run_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (clk_enable_i[3] && !st_ff.stop) |-> gate_en[3])
    else $error("run clock lost");

  irq_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_i |=> !stop_mode_o)
    else $error("interrupt did not wake");

  reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.ka_one & ~`KA_ONE_MASK) == 16'h0 && (st_ff.ka_two & ~`KA_TWO_MASK) == 16'h0)
    else $error("reserved bit set");

  write_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && adr_i == `KA_TWO_IDX && sel_i == 4'hf)
    |=> st_ff.ka_two == ($past(dat_i[15:0]) & `KA_TWO_MASK)) else $error("two write lost");

  write_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && adr_i == `KA_ONE_IDX && sel_i == 4'hf)
    |=> st_ff.ka_one == ($past(dat_i[15:0]) & `KA_ONE_MASK)) else $error("one write lost");

  nostop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    twowire_nostop_o |-> (stop_mode_o && st_ff.ka_one[6]))
    else $error("nostop wrong");

  reset_zero_a: assert property (@(posedge clk_i)
    rst_i |=> (st_ff.ka_one == 16'h0 && st_ff.ka_two == 16'h0))
    else $error("reset value");

  // With its clock-enable low a peripheral never gets a clock.
  en_off_can_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_enable_i[PER_CAN] |-> !gate_en[PER_CAN])
    else $error("CAN gate on with enable low");

  en_off_twowire_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_enable_i[PER_TWOWIRE] |-> !gate_en[PER_TWOWIRE])
    else $error("two-wire gate on with enable low");

  en_off_flash_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_enable_i[PER_FLASH1] |-> !gate_en[PER_FLASH1])
    else $error("flash gate on with enable low");

  en_off_cyclic_converter_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_enable_i[PER_CYCLIC_CONVERTER_KEEPALIVE] |-> !gate_en[PER_CYCLIC_CONVERTER_KEEPALIVE])
    else $error("converter gate on with enable low");

  en_off_comparator_d_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_enable_i[PER_COMPARATOR_D_KEEPALIVE] |-> !gate_en[PER_COMPARATOR_D_KEEPALIVE])
    else $error("comparator D gate on with enable low");

  en_off_comparator_c_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_enable_i[PER_COMPARATOR_C_KEEPALIVE] |-> !gate_en[PER_COMPARATOR_C_KEEPALIVE])
    else $error("comparator C gate on with enable low");

  en_off_comparator_b_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_enable_i[PER_COMPARATOR_B_KEEPALIVE] |-> !gate_en[PER_COMPARATOR_B_KEEPALIVE])
    else $error("comparator B gate on with enable low");

  en_off_comparator_a_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_enable_i[PER_COMPARATOR_A_KEEPALIVE] |-> !gate_en[PER_COMPARATOR_A_KEEPALIVE])
    else $error("comparator A gate on with enable low");

  // In stop mode a peripheral without keep-alive loses its clock.
  stop_off_can_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && !st_ff.ka_one[`KA_BIT_CAN]) |-> !gate_en[PER_CAN])
    else $error("CAN clocked in stop");

  stop_off_twowire_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && !st_ff.ka_one[`KA_BIT_TWOWIRE]) |-> !gate_en[PER_TWOWIRE])
    else $error("two-wire clocked in stop");

  stop_off_flash_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && !st_ff.ka_one[`KA_BIT_FLASH1]) |-> !gate_en[PER_FLASH1])
    else $error("flash clocked in stop");

  stop_off_cyclic_converter_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && !st_ff.ka_two[`KA_BIT_CYCLIC_CONVERTER_KEEPALIVE]) |-> !gate_en[PER_CYCLIC_CONVERTER_KEEPALIVE])
    else $error("converter clocked in stop");

  stop_off_comparator_d_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && !st_ff.ka_two[`KA_BIT_COMPARATOR_D_KEEPALIVE]) |-> !gate_en[PER_COMPARATOR_D_KEEPALIVE])
    else $error("comparator D clocked in stop");

  stop_off_comparator_c_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && !st_ff.ka_two[`KA_BIT_COMPARATOR_C_KEEPALIVE]) |-> !gate_en[PER_COMPARATOR_C_KEEPALIVE])
    else $error("comparator C clocked in stop");

  stop_off_comparator_b_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && !st_ff.ka_two[`KA_BIT_COMPARATOR_B_KEEPALIVE]) |-> !gate_en[PER_COMPARATOR_B_KEEPALIVE])
    else $error("comparator B clocked in stop");

  stop_off_comparator_a_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && !st_ff.ka_two[`KA_BIT_COMPARATOR_A_KEEPALIVE]) |-> !gate_en[PER_COMPARATOR_A_KEEPALIVE])
    else $error("comparator A clocked in stop");

  // In stop mode an enabled peripheral with keep-alive set keeps its clock.
  keep_on_can_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && clk_enable_i[PER_CAN] && st_ff.ka_one[`KA_BIT_CAN]) |-> gate_en[PER_CAN])
    else $error("CAN keep-alive lost");

  keep_on_twowire_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && clk_enable_i[PER_TWOWIRE] && st_ff.ka_one[`KA_BIT_TWOWIRE])
    |-> gate_en[PER_TWOWIRE]) else $error("two-wire keep-alive lost");

  keep_on_flash_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && clk_enable_i[PER_FLASH1] && st_ff.ka_one[`KA_BIT_FLASH1])
    |-> gate_en[PER_FLASH1]) else $error("flash keep-alive lost");

  keep_on_cyclic_converter_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && clk_enable_i[PER_CYCLIC_CONVERTER_KEEPALIVE] && st_ff.ka_two[`KA_BIT_CYCLIC_CONVERTER_KEEPALIVE])
    |-> gate_en[PER_CYCLIC_CONVERTER_KEEPALIVE]) else $error("converter keep-alive lost");

  keep_on_comparator_d_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && clk_enable_i[PER_COMPARATOR_D_KEEPALIVE] && st_ff.ka_two[`KA_BIT_COMPARATOR_D_KEEPALIVE])
    |-> gate_en[PER_COMPARATOR_D_KEEPALIVE]) else $error("comparator D keep-alive lost");

  keep_on_comparator_c_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && clk_enable_i[PER_COMPARATOR_C_KEEPALIVE] && st_ff.ka_two[`KA_BIT_COMPARATOR_C_KEEPALIVE])
    |-> gate_en[PER_COMPARATOR_C_KEEPALIVE]) else $error("comparator C keep-alive lost");

  keep_on_comparator_b_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && clk_enable_i[PER_COMPARATOR_B_KEEPALIVE] && st_ff.ka_two[`KA_BIT_COMPARATOR_B_KEEPALIVE])
    |-> gate_en[PER_COMPARATOR_B_KEEPALIVE]) else $error("comparator B keep-alive lost");

  keep_on_comparator_a_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.stop && clk_enable_i[PER_COMPARATOR_A_KEEPALIVE] && st_ff.ka_two[`KA_BIT_COMPARATOR_A_KEEPALIVE])
    |-> gate_en[PER_COMPARATOR_A_KEEPALIVE]) else $error("comparator A keep-alive lost");

  // In run mode every enabled peripheral is clocked.
  run_on_can_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_ff.stop && clk_enable_i[PER_CAN]) |-> gate_en[PER_CAN])
    else $error("CAN run clock lost");

  run_on_twowire_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_ff.stop && clk_enable_i[PER_TWOWIRE]) |-> gate_en[PER_TWOWIRE])
    else $error("two-wire run clock lost");

  run_on_flash_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_ff.stop && clk_enable_i[PER_FLASH1]) |-> gate_en[PER_FLASH1])
    else $error("flash run clock lost");

  run_on_cyclic_converter_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_ff.stop && clk_enable_i[PER_CYCLIC_CONVERTER_KEEPALIVE]) |-> gate_en[PER_CYCLIC_CONVERTER_KEEPALIVE])
    else $error("converter run clock lost");

  run_on_comparator_d_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_ff.stop && clk_enable_i[PER_COMPARATOR_D_KEEPALIVE]) |-> gate_en[PER_COMPARATOR_D_KEEPALIVE])
    else $error("comparator D run clock lost");

  run_on_comparator_c_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_ff.stop && clk_enable_i[PER_COMPARATOR_C_KEEPALIVE]) |-> gate_en[PER_COMPARATOR_C_KEEPALIVE])
    else $error("comparator C run clock lost");

  run_on_comparator_b_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_ff.stop && clk_enable_i[PER_COMPARATOR_B_KEEPALIVE]) |-> gate_en[PER_COMPARATOR_B_KEEPALIVE])
    else $error("comparator B run clock lost");

  run_on_comparator_a_keepalive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_ff.stop && clk_enable_i[PER_COMPARATOR_A_KEEPALIVE]) |-> gate_en[PER_COMPARATOR_A_KEEPALIVE])
    else $error("comparator A run clock lost");

  // Bus answer: one acknowledge per request, read data from the registers.
  req_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> ack_o)
    else $error("request not acknowledged");

  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");

  read_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && adr_i == `KA_ONE_IDX) |=> dat_o == {16'h0, $past(st_ff.ka_one)})
    else $error("first register read wrong");

  read_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && adr_i == `KA_TWO_IDX) |=> dat_o == {16'h0, $past(st_ff.ka_two)})
    else $error("second register read wrong");

  unmapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && adr_i != `KA_ONE_IDX && adr_i != `KA_TWO_IDX)
    |=> (dat_o == 32'h0 && $stable(st_ff.ka_one) && $stable(st_ff.ka_two)))
    else $error("unmapped access not refused");

  dat_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dat_o[31:16] == 16'h0)
    else $error("upper read data not zero");

  // Byte lanes: a lane without its select keeps its bits.
  write_one_lo_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && adr_i == `KA_ONE_IDX && sel_i[0])
    |=> st_ff.ka_one[7:0] == ($past(dat_i[7:0]) & `KA_ONE_MASK_LO)) else $error("one low lost");

  write_one_hi_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && adr_i == `KA_ONE_IDX && sel_i[1])
    |=> st_ff.ka_one[15:8] == ($past(dat_i[15:8]) & `KA_ONE_MASK_HI)) else $error("one high lost");

  write_two_lo_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && adr_i == `KA_TWO_IDX && sel_i[0])
    |=> st_ff.ka_two[7:0] == ($past(dat_i[7:0]) & `KA_TWO_MASK_LO)) else $error("two low lost");

  write_two_hi_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && adr_i == `KA_TWO_IDX && sel_i[1])
    |=> st_ff.ka_two[15:8] == ($past(dat_i[15:8]) & `KA_TWO_MASK_HI)) else $error("two high lost");

  one_lo_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && adr_i == `KA_ONE_IDX && !sel_i[0]) |=> $stable(st_ff.ka_one[7:0]))
    else $error("unselected first low byte changed");

  one_hi_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && adr_i == `KA_ONE_IDX && !sel_i[1]) |=> $stable(st_ff.ka_one[15:8]))
    else $error("unselected first high byte changed");

  two_lo_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && adr_i == `KA_TWO_IDX && !sel_i[0]) |=> $stable(st_ff.ka_two[7:0]))
    else $error("unselected second low byte changed");

  two_hi_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && adr_i == `KA_TWO_IDX && !sel_i[1]) |=> $stable(st_ff.ka_two[15:8]))
    else $error("unselected second high byte changed");

  // Stop state: entered on request, left on interrupt, interrupt wins.
  stop_enter_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (stop_req_i && !irq_i) |=> stop_mode_o)
    else $error("stop request ignored");

  stop_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!stop_req_i && !irq_i) |=> $stable(stop_mode_o))
    else $error("stop state changed by itself");

  irq_priority_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (stop_req_i && irq_i) |=> !stop_mode_o)
    else $error("stop won over interrupt");

  nostop_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (stop_mode_o && st_ff.ka_one[`KA_BIT_TWOWIRE]) |-> twowire_nostop_o)
    else $error("two-wire stop not blocked");

  nostop_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !stop_mode_o |-> !twowire_nostop_o)
    else $error("two-wire stop blocked in run");

  reset_state_a: assert property (@(posedge clk_i)
    rst_i |=> (!stop_mode_o && !ack_o && dat_o == 32'h0))
    else $error("reset state wrong");
endmodule // stop_keepalive
`default_nettype wire

// [shared/keepalive_defs.svh]
// Constants for the stop-mode clock keep-alive block: offsets, bit positions, reset values.
// Assumes a classic Wishbone slave with 32-bit data, one register per aligned word.
// Operation
// - Without keep-alive, a peripheral clock is removed whenever the chip is in stop.
// - A set keep-alive bit keeps the peripheral clocked through stop mode.
// - Keep-alive supplies the stop clock only when clock-enable is also one.
// - Clock-enable zero turns the clock off in every mode, keep-alive ignored.
// - Bus accesses cannot reach a gated peripheral; software must not rely on them.
// - Two-wire keep-alive is bit 6; it also blocks that controller's own stop.
// - Reserved bits read zero: first register 15..9, 7 and 5..1, second 15..13, 8 and 6..0.
// - First register: bit 8 second serial flash interface, bit 0 CAN controller.
// - Second register bits 12..9 cover comparators A..D with their reference DACs.
// - Second register bit 7 covers the cyclic converter.
// - Keep-alive value 0 means not clocked in stop, 1 means clocked.
// - An asserted interrupt returns the system from stop to run.
// - Second keep-alive register decodes at index 12h.
// - First keep-alive register decodes at index 11h.
`ifndef KEEPALIVE_DEFS_SVH
`define KEEPALIVE_DEFS_SVH
`define KA_ONE_IDX      8'h11
`define KA_TWO_IDX      8'h12
`define KA_ONE_MASK     16'h0141
`define KA_TWO_MASK     16'h1e80
`define KA_ONE_MASK_LO  8'h41
`define KA_ONE_MASK_HI  8'h01
`define KA_TWO_MASK_LO  8'h80
`define KA_TWO_MASK_HI  8'h1e
`define KA_RESET        16'h0000
`define KA_BIT_FLASH1   8
`define KA_BIT_TWOWIRE  6
`define KA_BIT_CAN      0
`define KA_BIT_COMPARATOR_A_KEEPALIVE     12
`define KA_BIT_COMPARATOR_B_KEEPALIVE     11
`define KA_BIT_COMPARATOR_C_KEEPALIVE     10
`define KA_BIT_COMPARATOR_D_KEEPALIVE     9
`define KA_BIT_CYCLIC_CONVERTER_KEEPALIVE   7
`endif

// [shared/keepalive_pkg.sv]
// Types for the stop-mode clock keep-alive block.
// Assumes keepalive_defs.svh is compiled alongside.
package keepalive_pkg;
  // Peripheral order on the gate vectors.
  typedef enum logic [2:0] {
    PER_CAN     = 3'h0,
    PER_TWOWIRE = 3'h1,
    PER_FLASH1  = 3'h2,
    PER_CYCLIC_CONVERTER_KEEPALIVE  = 3'h3,
    PER_COMPARATOR_D_KEEPALIVE    = 3'h4,
    PER_COMPARATOR_C_KEEPALIVE    = 3'h5,
    PER_COMPARATOR_B_KEEPALIVE    = 3'h6,
    PER_COMPARATOR_A_KEEPALIVE    = 3'h7
  } periph_t;
  typedef logic [7:0] per_vec_t;
  typedef struct packed {
    logic [15:0] ka_one;
    logic [15:0] ka_two;
    logic        ack;
    logic [31:0] dat;
    logic        stop;
  } ka_state_t;
endpackage

// [tb/gate_watch.sv]
// Peripheral-side model: records which gated clocks pulsed since the last clear.
// Assumes each gate is the bus clock ANDed with a latched enable.
`timescale 1ns/1ps
`default_nettype none
module gate_watch (
  input  wire logic [7:0] gate_i,  // Gated peripheral clocks.
  input  wire logic       clr_i,   // Forgets pulses seen so far.
  output wire logic [7:0] seen_o   // Clocks that pulsed since clear.
);
  for (genvar i = 0; i < 8; i++) begin : g_bit
    logic hit;
    always @(posedge gate_i[i] or posedge clr_i) begin
      hit <= !clr_i;
    end
    assign seen_o[i] = hit;
  end
endmodule // gate_watch
`default_nettype wire

// [tb/tb_stop_keepalive.sv]
// Self-checking bench for the stop-mode keep-alive block.
// Assumes a Wishbone classic slave answering one cycle after each request.
`timescale 1ns/1ps
`default_nettype none
`include "keepalive_defs.svh"
module tb_stop_keepalive;
  import keepalive_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, stop_req, irq, clr, stop, nostop;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_w, dat_r, q;
  per_vec_t    en, gate, seen;
  int          fails = 0, samples_checked = 0;
  logic [39:0] rows [4] = '{{16'hffff, 16'hffff, 8'hff}, {16'h0000, 16'h0000, 8'hff},
                            {16'hffff, 16'hffff, 8'h00}, {16'h0041, 16'h0a80, 8'h5b}};
  stop_keepalive DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .clk_enable_i(en),
    .stop_req_i(stop_req), .irq_i(irq), .stop_mode_o(stop), .clk_gate_o(gate),
    .twowire_nostop_o(nostop));
  gate_watch watch (.gate_i(gate), .clr_i(clr), .seen_o(seen));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat_w, sel} <= {2'b11, w, a, d, s};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      conclude();
    end
    q = dat_r;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic gates(input per_vec_t e);
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (3) @(posedge clk_i);
    cmp("gates", {24'h0, e}, {24'h0, seen});
  endtask
  task automatic conclude;
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk_i = 0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #300000;
    fails++;
    conclude();
  end
  initial begin : main
    logic [15:0] k1, k2;
    {rst_i, cyc, stb, we, adr, sel, dat_w, en, stop_req, irq, clr} = '0;
    rst_i = 1;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    foreach (rows[i]) begin
      {k1, k2} = rows[i][39:8];
      en <= rows[i][7:0];
      wb(1, `KA_ONE_IDX, {16'h0, k1}, 4'hf);
      wb(1, `KA_TWO_IDX, {16'h0, k2}, 4'hf);
      wb(0, `KA_ONE_IDX, 0, 4'hf);
      cmp("ka_one", {16'h0, k1 & 16'h0141}, q);
      wb(0, `KA_TWO_IDX, 0, 4'hf);
      cmp("ka_two", {16'h0, k2 & 16'h1e80}, q);
      gates(en);
      stop_req <= 1;
      gates(en & {k2[12:9], k2[7], k1[8], k1[6], k1[0]});
      cmp("stop_on", 1, {31'h0, stop});
      cmp("nostop", {31'h0, k1[6]}, {31'h0, nostop});
      irq <= 1;
      @(posedge clk_i);
      {stop_req, irq} <= 2'b00;
      @(posedge clk_i);
      cmp("stop", 0, {31'h0, stop});
    end
    wb(1, `KA_ONE_IDX, 32'hffff, 4'h1);
    wb(0, `KA_ONE_IDX, 0, 4'hf);
    cmp("byte_sel", 32'h0041, q);
    wb(1, `KA_TWO_IDX, 32'hffff, 4'h2);
    wb(0, `KA_TWO_IDX, 0, 4'hf);
    cmp("byte_sel_two", 32'h1e80, q);
    wb(1, 8'h13, 32'hffff, 4'hf);
    cmp("unmapped", 0, q);
    @(posedge clk_i);
    rst_i <= 1;
    @(posedge clk_i);
    rst_i <= 0;
    wb(0, `KA_ONE_IDX, 0, 4'hf);
    cmp("reset", 0, q);
    conclude();
  end
endmodule // tb_stop_keepalive
`default_nettype wire
